// File: dv/dfbi_partner.sv
`timescale 1ns/1ps
module dfbi_partner (
  // audio pins
  output logic frame_clock_pin,
  output logic bit_clock_pin,
  output logic data_pin,
  output logic sys_clock_pin,
  // dual-line data
  output logic left_line,
  output logic right_line
);
  initial begin
    {frame_clock_pin, bit_clock_pin, data_pin, sys_clock_pin, left_line, right_line} = 6'h00;
  end
  // one word pair, word clock toggles per word
  task automatic send_pair(input logic [23:0] l, input logic [23:0] r);
    for (int h = 0; h < 2; h++) begin
      for (int i = 23; i >= 0; i--) begin
        bit_clock_pin = 1'b0;
        data_pin = h ? r[i] : l[i];
        left_line = l[i];
        right_line = r[i];
        #200;
        bit_clock_pin = 1'b1;
        #200;
      end
      bit_clock_pin = 1'b0;
      frame_clock_pin = ~frame_clock_pin;
      #400;
    end
    data_pin = ~data_pin;
    left_line = ~left_line;
    right_line = ~right_line;
  endtask : send_pair
  // eight bit pairs, bit clock still outside the burst
  task automatic send_bits(input logic [7:0] l, input logic [7:0] r);
    bit_clock_pin = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      data_pin = l[i];
      frame_clock_pin = r[i];
      #200;
      sys_clock_pin = 1'b1;
      #200;
      sys_clock_pin = 1'b0;
    end
    data_pin = ~data_pin;
    frame_clock_pin = ~frame_clock_pin;
  endtask : send_bits
endmodule : dfbi_partner

// File: dv/dfbi_top_tb.sv
`timescale 1ns/1ps
module dfbi_top_tb;
  typedef struct packed {
    logic [15:0] w;
    logic [7:0]  e;
  } dfbi_row_t;
  logic                   clk, rst_n, ctl_clk, ctl_sel_n, ctl_din, ctl_dout_o, ctl_dout_oe_n;
  logic                   frame_clock_pin, bit_clock_pin, data_pin, sys_clock_pin;
  logic                   left_zero_pin_i, left_zero_pin_o, left_zero_pin_oe_n;
  logic                   right_zero_pin_i, right_zero_pin_o, right_zero_pin_oe_n;
  logic                   smp_valid, smp_ready, sys_reset_pulse, overflow_r, left_line, right_line;
  dfbi_pkg::dfbi_sample_t smp_data;
  dfbi_pkg::dfbi_cfg_t    cfg;
  dfbi_pkg::dfbi_sample_t got_q[$];
  int                     failures, comparisons, pulses;
  dfbi_row_t              rows [13] = '{
    '{16'h9200, 8'h00}, '{16'h9300, 8'h00}, '{16'h9400, 8'h00}, '{16'h9500, 8'h01},
    '{16'h9600, 8'h00}, '{16'hB000, 8'h00}, '{16'h1410, 8'h00}, '{16'h12FF, 8'h00},
    '{16'h9200, 8'h70}, '{16'h13FF, 8'h00}, '{16'h9300, 8'h95}, '{16'h15FF, 8'h00},
    '{16'h9500, 8'h01}
  };
  // zero pins resolved from both parties
  assign left_zero_pin_i  = left_zero_pin_oe_n ? left_line : left_zero_pin_o;
  assign right_zero_pin_i = right_zero_pin_oe_n ? right_line : right_zero_pin_o;
  dfbi_top dut_u (
    .clk, .rst_n, .ctl_clk, .ctl_sel_n, .ctl_din, .ctl_dout_o, .ctl_dout_oe_n,
    .frame_clock_pin, .bit_clock_pin, .data_pin, .sys_clock_pin,
    .left_zero_pin_i, .left_zero_pin_o, .left_zero_pin_oe_n,
    .right_zero_pin_i, .right_zero_pin_o, .right_zero_pin_oe_n,
    .smp_valid, .smp_ready, .smp_data, .cfg, .sys_reset_pulse, .overflow_r
  );
  dfbi_partner p_u (
    .frame_clock_pin, .bit_clock_pin, .data_pin, .sys_clock_pin, .left_line, .right_line
  );
  always #25 clk = ~clk;
  always @(negedge clk) begin
    #1;
    if (smp_valid === 1'b1 && smp_ready === 1'b1) got_q.push_back(smp_data);
    if (sys_reset_pulse === 1'b1) pulses++;
  end
  // ****************
  // tasks
  // ****************
  task automatic chk_word(input string s, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk_word
  task automatic chk_bit(input string s, input logic e, input logic g);
    chk_word(s, {23'h000000, e}, {23'h000000, g});
  endtask : chk_bit
  task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
    rd = 8'h00;
    ctl_sel_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      ctl_din = w[i];
      repeat (4) @(negedge clk);
      if (i < 8) rd[i] = ctl_dout_o;
      if (i == 0) chk_bit("dout oe_n", !w[15], ctl_dout_oe_n);
      ctl_clk = 1'b1;
      repeat (4) @(negedge clk);
      ctl_clk = 1'b0;
    end
    repeat (4) @(negedge clk);
    ctl_sel_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask : xfer
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    xfer({1'b0, a, d}, x);
  endtask : wr
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] x;
    xfer({1'b1, a, 8'h00}, x);
    chk_word("register", {16'h0000, e}, {16'h0000, x});
  endtask : rdchk
  task automatic wait_q(input int n);
    for (int k = 0; k < 2000 && got_q.size() < n; k++) @(negedge clk);
  endtask : wait_q
  task automatic close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  // ****************
  // tests
  // ****************
  initial begin
    #2000000;
    failures++;
    close_out();
  end
  initial begin
    logic [7:0]  rd;
    logic [23:0] msk;
    logic [1:0]  spd;
    {clk, rst_n, ctl_clk, ctl_din} = 4'h0;
    {ctl_sel_n, smp_ready} = 2'h3;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk_bit("smp_valid", 1'b0, smp_valid);
    foreach (rows[n]) begin
      xfer(rows[n].w, rd);
      if (rows[n].w[15]) chk_word("row", {16'h0000, rows[n].e}, {16'h0000, rd});
    end
    chk_bit("bypass", 1'b1, cfg.filter_bypass);
    chk_bit("bitstream", 1'b0, cfg.bitstream_mode);
    $display("test rows done");
    for (int o = 2; o >= 0; o--) begin
      wr(7'h14, 8'h10 | 8'(o));
      chk_word("ratio", (o == 0) ? 24'h000008 : (o == 1) ? 24'h000004 : 24'h000010, 24'(cfg.modulator_ratio));
    end
    wr(7'h13, 8'h00);
    for (int f = 0; f < 3; f++) begin
      wr(7'h12, 8'(f << 4));
      got_q.delete();
      p_u.send_pair(24'hA5C3F1, 24'h5A3C1E);
      wait_q(1);
      msk = 24'hFFFFFF >> (8 - 4 * f);
      chk_word("left", 24'hA5C3F1 & msk, got_q[0].left);
      chk_word("right", 24'h5A3C1E & msk, got_q[0].right);
    end
    $display("test formats done");
    wr(7'h13, 8'h04);
    chk_bit("oe_n", 1'b1, left_zero_pin_oe_n);
    got_q.delete();
    p_u.send_pair(24'h123456, 24'hFEDCBA);
    wait_q(1);
    chk_word("dual left", 24'h123456, got_q[0].left);
    chk_word("dual right", 24'hFEDCBA, got_q[0].right);
    wr(7'h13, 8'h00);
    chk_bit("oe_n", 1'b0, right_zero_pin_oe_n);
    $display("test dual done");
    smp_ready = 1'b0;
    got_q.delete();
    for (int k = 0; k < 3; k++) p_u.send_pair(24'(k + 1), 24'(k + 8));
    chk_bit("overflow", 1'b1, overflow_r);
    chk_bit("valid", 1'b1, smp_valid);
    smp_ready = 1'b1;
    wait_q(2);
    repeat (4) @(negedge clk);
    chk_word("count", 24'h000002, 24'(got_q.size()));
    chk_word("first", 24'h000001, got_q[0].left);
    chk_word("second", 24'h000002, got_q[1].left);
    chk_bit("drained", 1'b0, smp_valid);
    $display("test buffer done");
    p_u.send_pair(24'h000000, 24'h000000);
    repeat (8) @(negedge clk);
    chk_bit("zero l", 1'b1, left_zero_pin_o);
    rdchk(7'h16, 8'h03);
    pulses = 0;
    wr(7'h14, 8'h50);
    chk_word("pulses", 24'h000001, 24'(pulses));
    rdchk(7'h14, 8'h00);
    rdchk(7'h15, 8'h01);
    chk_bit("overflow", 1'b0, overflow_r);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      spd = (k == 1) ? 2'h1 : (k == 2) ? 2'h3 : 2'h0;
      wr(7'h14, {6'h00, spd});
      wr(7'h12, {4'h0, 2'(k), 2'h0});
      wr(7'h14, {6'h08, spd});
      chk_bit("mode", 1'b1, cfg.bitstream_mode);
      chk_word("fir", 24'(k), 24'(cfg.fir_response_select));
      chk_word("speed", 24'(spd), 24'(cfg.oversample_speed));
      got_q.delete();
      p_u.send_bits(8'hA5, 8'h3C);
      repeat (20) @(negedge clk);
      chk_word("pushes", 24'(8 >> (k % 3)), 24'(got_q.size()));
      if (k == 0) chk_bit("bit l", 1'b1, got_q[0].left[0]);
      if (k == 0) chk_bit("bit r", 1'b0, got_q[0].right[0]);
    end
    wr(7'h13, 8'hFF);
    rdchk(7'h13, 8'h90);
    wr(7'h15, 8'h04);
    p_u.send_bits(8'h96, 8'h96);
    repeat (8) @(negedge clk);
    chk_bit("zero 96", 1'b1, right_zero_pin_o);
    wr(7'h15, 8'h02);
    p_u.send_bits(8'h0F, 8'h07);
    repeat (8) @(negedge clk);
    chk_bit("even l", 1'b1, left_zero_pin_o);
    chk_bit("even r", 1'b0, right_zero_pin_o);
    $display("test bitstream done");
    close_out();
  end
endmodule : dfbi_top_tb

// File: rtl/dfbi_buf.sv
`timescale 1ns/1ps
module dfbi_buf #(
  parameter int W = 49
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] ent_r [2];
  logic [W-1:0] ent_nxt [2];
  logic [1:0]   cnt_r;
  logic [1:0]   cnt_nxt;
  logic         push;
  logic         pop;

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = ent_r[0];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    ent_nxt[0] = ent_r[0];
    ent_nxt[1] = ent_r[1];
    cnt_nxt    = cnt_r;
    if (pop) begin
      ent_nxt[0] = ent_r[1];
    end
    if (push) begin
      if (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)) begin
        ent_nxt[0] = in_data;
      end else begin
        ent_nxt[1] = in_data;
      end
    end
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ent_r[0] <= '0;
      ent_r[1] <= '0;
      cnt_r    <= 2'h0;
    end else begin
      ent_r[0] <= ent_nxt[0];
      ent_r[1] <= ent_nxt[1];
      cnt_r    <= cnt_nxt;
    end
  end
endmodule : dfbi_buf

// File: rtl/dfbi_pkg.sv
// Contract
// - bypass bit set, bitstream clear: external filter mode
// - frame pin word clock, bit pin clocks data
// - dual-line uses zero pins as data inputs
// - format 000/001/010 gives 16/20/24-bit words
// - oversample 00 8x, 01 4x, 10 16x
// - disabled bits ignore writes per mode
// - bitstream mode bit set: bitstream mode
// - bitstream pins: data, frame, system clock
// - fir response field picks one of four
// - speed 00 full, 01 half, 11 quarter
// - control word: rw msb, 7-bit index, data
// - zero field: off, even, 96h pattern
// - zero status bits mirror zero pins
// - reset bit write gives one reset pulse
package dfbi_pkg;
  // ****************
  // register indexes
  // ****************
  localparam logic [6:0] REG_INACT_A = 7'h10;
  localparam logic [6:0] REG_INACT_B = 7'h11;
  localparam logic [6:0] REG_FMT_FIR = 7'h12;
  localparam logic [6:0] REG_OUT_OPT = 7'h13;
  localparam logic [6:0] REG_SYS_MODE = 7'h14;
  localparam logic [6:0] REG_ZERO_EN = 7'h15;
  localparam logic [6:0] REG_ZERO_ST = 7'h16;
  // ****************
  // field positions
  // ****************
  localparam int BIT_RESET = 6;
  localparam int BIT_BITSTREAM = 5;
  localparam int BIT_BYPASS = 4;
  localparam int BIT_SINGLE_CHANNEL_MODE = 3;
  localparam int BIT_CHPICK = 2;
  localparam int BIT_OS_LO = 0;
  localparam int BIT_FMT_LO = 4;
  localparam int BIT_FIR_LO = 2;
  localparam int BIT_REV = 7;
  localparam int BIT_OPE = 4;
  localparam int BIT_DUAL = 2;
  localparam int BIT_ZERO_DETECT_MUTE = 0;
  localparam int BIT_DZ_LO = 1;
  localparam int BIT_WZ = 0;
  localparam int CW_BITS = 16;
  localparam int CW_HALF = 8;
  // ****************
  // reset values and write masks
  // ****************
  localparam logic [7:0] RST_FMT_FIR = 8'h00;
  localparam logic [7:0] RST_OUT_OPT = 8'h00;
  localparam logic [7:0] RST_SYS_MODE = 8'h00;
  localparam logic [7:0] RST_ZERO_EN = 8'h01;
  localparam logic [7:0] MSK_FMT_NORM = 8'h7C;
  localparam logic [7:0] MSK_FMT_FILT = 8'h70;
  localparam logic [7:0] MSK_FMT_BS = 8'h0C;
  localparam logic [7:0] MSK_OPT_NORM = 8'h95;
  localparam logic [7:0] MSK_OPT_FILT = 8'h95;
  localparam logic [7:0] MSK_OPT_BS = 8'h90;
  localparam logic [7:0] MSK_SYS_NORM = 8'h3F;
  localparam logic [7:0] MSK_SYS_FILT = 8'h3F;
  localparam logic [7:0] MSK_SYS_BS = 8'h2F;
  localparam logic [7:0] MSK_ZER_NORM = 8'h07;
  localparam logic [7:0] MSK_ZER_FILT = 8'h01;
  localparam logic [7:0] MSK_ZER_BS = 8'h06;
  // ****************
  // codes
  // ****************
  localparam logic [2:0] FMT_16 = 3'h0;
  localparam logic [2:0] FMT_20 = 3'h1;
  localparam logic [2:0] FMT_24 = 3'h2;
  localparam logic [1:0] OS_8X = 2'h0;
  localparam logic [1:0] OS_4X = 2'h1;
  localparam logic [1:0] OS_16X = 2'h2;
  localparam logic [1:0] SPD_FULL = 2'h0;
  localparam logic [1:0] SPD_HALF = 2'h1;
  localparam logic [1:0] SPD_QUART = 2'h3;
  localparam logic [7:0] PAT_96 = 8'h96;
  localparam logic [3:0] EVEN_ONES = 4'h4;
  localparam int WORD_W = 24;

  typedef struct packed {
    logic              bitstream;
    logic [WORD_W-1:0] left;
    logic [WORD_W-1:0] right;
  } dfbi_sample_t;

  typedef struct packed {
    logic       filter_bypass;
    logic       bitstream_mode;
    logic [2:0] word_format;
    logic [1:0] fir_response_select;
    logic [1:0] oversample_speed;
    logic [4:0] modulator_ratio;
    logic       single_channel_mode;
    logic       channel_pick;
    logic       polarity_invert;
    logic       output_disable;
    logic       zero_detect_mute;
  } dfbi_cfg_t;
endpackage : dfbi_pkg

// File: rtl/dfbi_top.sv
`timescale 1ns/1ps
module dfbi_top (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // serial control port
  input  wire logic                  ctl_clk,
  input  wire logic                  ctl_sel_n,
  input  wire logic                  ctl_din,
  output logic                       ctl_dout_o,
  output logic                       ctl_dout_oe_n,
  // audio pins
  input  wire logic                  frame_clock_pin,
  input  wire logic                  bit_clock_pin,
  input  wire logic                  data_pin,
  input  wire logic                  sys_clock_pin,
  // zero pins, two-way
  input  wire logic                  left_zero_pin_i,
  output logic                       left_zero_pin_o,
  output logic                       left_zero_pin_oe_n,
  input  wire logic                  right_zero_pin_i,
  output logic                       right_zero_pin_o,
  output logic                       right_zero_pin_oe_n,
  // sample stream out
  output logic                       smp_valid,
  input  wire logic                  smp_ready,
  output dfbi_pkg::dfbi_sample_t     smp_data,
  // configuration and status
  output dfbi_pkg::dfbi_cfg_t        cfg,
  output logic                       sys_reset_pulse,
  output logic                       overflow_r
);
  // ****************
  // pin synchronisers
  // ****************
  localparam int NS = 8;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] s1_r;
  logic [NS-1:0] s2_r;
  logic [NS-1:0] s3_r;
  assign pin_raw = {ctl_clk, ctl_sel_n, ctl_din, frame_clock_pin, bit_clock_pin,
                    data_pin, sys_clock_pin, left_zero_pin_i};
  logic rz_s1_r;
  logic rz_s2_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r    <= 8'h40; // select idles high
      s2_r    <= 8'h40;
      s3_r    <= 8'h40;
      rz_s1_r <= 1'b0;
      rz_s2_r <= 1'b0;
    end else begin
      s1_r    <= pin_raw;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      rz_s1_r <= right_zero_pin_i;
      rz_s2_r <= rz_s1_r;
    end
  end
  logic c_clk, c_sel_n, c_din, wclk, bclk, dpin, sclk_p, lz_in, rz_in;
  logic c_rise, c_fall, w_rise, w_fall, b_rise, s_rise;
  assign {c_clk, c_sel_n, c_din, wclk, bclk, dpin, sclk_p, lz_in} = s2_r;
  assign rz_in  = rz_s2_r;
  assign c_rise = s2_r[7] && !s3_r[7];
  assign c_fall = !s2_r[7] && s3_r[7];
  assign w_rise = s2_r[4] && !s3_r[4];
  assign w_fall = !s2_r[4] && s3_r[4];
  assign b_rise = s2_r[3] && !s3_r[3];
  assign s_rise = s2_r[1] && !s3_r[1];

  // ****************
  // control registers
  // ****************
  logic [7:0] fmt_r, opt_r, sys_r, zen_r;
  logic [7:0] fmt_nxt, opt_nxt, sys_nxt, zen_nxt;
  logic [15:0] sr_r, sr_nxt;
  logic [4:0]  cnt_r, cnt_nxt;
  logic [7:0]  out_sr_r, out_sr_nxt;
  logic        dout_r, dout_nxt;
  logic        system_reset_bit_r, system_reset_bit_nxt;
  logic        filt_mode, bs_mode;
  logic [7:0]  rdata;
  logic [7:0]  zst;
  logic        wr_go;
  logic [7:0]  wdat;
  logic [7:0]  msk_fmt, msk_opt, msk_sys, msk_zen;

  localparam int BIT_BS = dfbi_pkg::BIT_BITSTREAM;
  assign filt_mode = !sys_r[BIT_BS] && sys_r[dfbi_pkg::BIT_BYPASS];
  assign bs_mode   = sys_r[BIT_BS];
  assign wdat      = {sr_r[6:0], c_din};
  assign wr_go     = !c_sel_n && c_rise && cnt_r == 5'(dfbi_pkg::CW_BITS - 1) && !sr_r[14];

  always_comb begin
    msk_fmt = dfbi_pkg::MSK_FMT_NORM;
    msk_opt = dfbi_pkg::MSK_OPT_NORM;
    msk_sys = dfbi_pkg::MSK_SYS_NORM;
    msk_zen = dfbi_pkg::MSK_ZER_NORM;
    if (bs_mode) begin
      msk_fmt = dfbi_pkg::MSK_FMT_BS;
      msk_opt = dfbi_pkg::MSK_OPT_BS;
      msk_sys = dfbi_pkg::MSK_SYS_BS;
      msk_zen = dfbi_pkg::MSK_ZER_BS;
    end else if (filt_mode) begin
      msk_fmt = dfbi_pkg::MSK_FMT_FILT;
      msk_opt = dfbi_pkg::MSK_OPT_FILT;
      msk_sys = dfbi_pkg::MSK_SYS_FILT;
      msk_zen = dfbi_pkg::MSK_ZER_FILT;
    end
  end

  always_comb begin
    case (sr_r[6:0])
      dfbi_pkg::REG_FMT_FIR:  rdata = fmt_r;
      dfbi_pkg::REG_OUT_OPT:  rdata = opt_r;
      dfbi_pkg::REG_SYS_MODE: rdata = sys_r;
      dfbi_pkg::REG_ZERO_EN:  rdata = zen_r;
      dfbi_pkg::REG_ZERO_ST:  rdata = zst;
      default:                rdata = 8'h00;
    endcase
  end

  always_comb begin
    sr_nxt     = sr_r;
    cnt_nxt    = cnt_r;
    out_sr_nxt = out_sr_r;
    dout_nxt   = dout_r;
    fmt_nxt    = fmt_r;
    opt_nxt    = opt_r;
    sys_nxt    = sys_r;
    zen_nxt    = zen_r;
    system_reset_bit_nxt   = 1'b0;
    if (c_sel_n) begin
      cnt_nxt = 5'h0;
    end else if (c_rise && cnt_r < 5'(dfbi_pkg::CW_BITS)) begin
      sr_nxt  = {sr_r[14:0], c_din};
      cnt_nxt = cnt_r + 5'h1;
      if (cnt_r == 5'(dfbi_pkg::CW_HALF - 1)) begin
        sr_nxt = {8'h00, sr_r[6:0], c_din};
      end
    end else if (c_fall && cnt_r >= 5'(dfbi_pkg::CW_HALF) && cnt_r < 5'(dfbi_pkg::CW_BITS)) begin
      if (cnt_r == 5'(dfbi_pkg::CW_HALF)) begin
        dout_nxt   = rdata[7];
        out_sr_nxt = {rdata[6:0], 1'b0};
      end else begin
        dout_nxt   = out_sr_r[7];
        out_sr_nxt = {out_sr_r[6:0], 1'b0};
      end
    end
    if (wr_go) begin
      case (sr_r[13:7])
        dfbi_pkg::REG_FMT_FIR:  fmt_nxt = (fmt_r & ~msk_fmt) | (wdat & msk_fmt);
        dfbi_pkg::REG_OUT_OPT:  opt_nxt = (opt_r & ~msk_opt) | (wdat & msk_opt);
        dfbi_pkg::REG_SYS_MODE: begin
          sys_nxt  = (sys_r & ~msk_sys) | (wdat & msk_sys);
          system_reset_bit_nxt = wdat[dfbi_pkg::BIT_RESET];
        end
        dfbi_pkg::REG_ZERO_EN:  zen_nxt = (zen_r & ~msk_zen) | (wdat & msk_zen);
        default:                sr_nxt = sr_nxt;
      endcase
    end
    if (system_reset_bit_r) begin
      fmt_nxt = dfbi_pkg::RST_FMT_FIR;
      opt_nxt = dfbi_pkg::RST_OUT_OPT;
      sys_nxt = dfbi_pkg::RST_SYS_MODE;
      zen_nxt = dfbi_pkg::RST_ZERO_EN;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_r     <= '0;
      cnt_r    <= '0;
      out_sr_r <= '0;
      dout_r   <= 1'b0;
      fmt_r    <= dfbi_pkg::RST_FMT_FIR;
      opt_r    <= dfbi_pkg::RST_OUT_OPT;
      sys_r    <= dfbi_pkg::RST_SYS_MODE;
      zen_r    <= dfbi_pkg::RST_ZERO_EN;
      system_reset_bit_r   <= 1'b0;
    end else begin
      sr_r     <= sr_nxt;
      cnt_r    <= cnt_nxt;
      out_sr_r <= out_sr_nxt;
      dout_r   <= dout_nxt;
      fmt_r    <= fmt_nxt;
      opt_r    <= opt_nxt;
      sys_r    <= sys_nxt;
      zen_r    <= zen_nxt;
      system_reset_bit_r   <= system_reset_bit_nxt;
    end
  end
  logic rd_sel_r;
  assign ctl_dout_o      = dout_r;
  assign ctl_dout_oe_n   = !(!c_sel_n && cnt_r >= 5'(dfbi_pkg::CW_HALF) && rd_sel_r);
  assign sys_reset_pulse = system_reset_bit_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_sel_r <= 1'b0;
    end else if (c_sel_n) begin
      rd_sel_r <= 1'b0;
    end else if (c_rise && cnt_r == 5'h0) begin
      rd_sel_r <= c_din;
    end
  end

  // ****************
  // configuration decode
  // ****************
  always_comb begin
    cfg                     = '0;
    cfg.filter_bypass       = filt_mode;
    cfg.bitstream_mode      = bs_mode;
    cfg.word_format         = fmt_r[dfbi_pkg::BIT_FMT_LO +: 3];
    cfg.fir_response_select = fmt_r[dfbi_pkg::BIT_FIR_LO +: 2];
    cfg.oversample_speed    = sys_r[dfbi_pkg::BIT_OS_LO +: 2];
    cfg.single_channel_mode = sys_r[dfbi_pkg::BIT_SINGLE_CHANNEL_MODE];
    cfg.channel_pick        = sys_r[dfbi_pkg::BIT_CHPICK];
    cfg.polarity_invert     = opt_r[dfbi_pkg::BIT_REV];
    cfg.output_disable      = opt_r[dfbi_pkg::BIT_OPE];
    cfg.zero_detect_mute    = opt_r[dfbi_pkg::BIT_ZERO_DETECT_MUTE];
    case (cfg.oversample_speed)
      dfbi_pkg::OS_8X:  cfg.modulator_ratio = 5'd8;
      dfbi_pkg::OS_4X:  cfg.modulator_ratio = 5'd4;
      dfbi_pkg::OS_16X: cfg.modulator_ratio = 5'd16;
      default:          cfg.modulator_ratio = 5'd0;
    endcase
  end

  // ****************
  // word and bitstream capture
  // ****************
  logic        dual;
  logic [23:0] lsh_r, rsh_r, lsh_nxt, rsh_nxt;
  logic [23:0] lw_r, lw_nxt;
  logic [23:0] wmask;
  logic [1:0]  div_r, div_nxt;
  logic [7:0]  lh_r, rh_r, lh_nxt, rh_nxt;
  logic        push, push_nxt;
  dfbi_pkg::dfbi_sample_t pdat_r, pdat_nxt;
  logic        in_ready;
  logic        ovf_nxt;
  assign dual = filt_mode && opt_r[dfbi_pkg::BIT_DUAL];
  always_comb begin
    case (cfg.word_format)
      dfbi_pkg::FMT_20: wmask = 24'h0FFFFF;
      dfbi_pkg::FMT_24: wmask = 24'hFFFFFF;
      default:          wmask = 24'h00FFFF;
    endcase
  end

  always_comb begin
    lsh_nxt  = lsh_r;
    rsh_nxt  = rsh_r;
    lw_nxt   = lw_r;
    div_nxt  = div_r;
    lh_nxt   = lh_r;
    rh_nxt   = rh_r;
    push_nxt = 1'b0;
    pdat_nxt = pdat_r;
    ovf_nxt  = overflow_r || (push && !in_ready);
    if (filt_mode) begin
      if (b_rise) begin
        lsh_nxt = {lsh_r[22:0], dual ? lz_in : dpin};
        rsh_nxt = {rsh_r[22:0], rz_in};
      end
      if (w_rise) begin
        lw_nxt = lsh_r & wmask;
        if (dual) begin
          push_nxt = 1'b1;
          pdat_nxt = '{bitstream: 1'b0, left: lsh_r & wmask, right: rsh_r & wmask};
        end
      end else if (w_fall && !dual) begin
        push_nxt = 1'b1;
        pdat_nxt = '{bitstream: 1'b0, left: lw_r, right: lsh_r & wmask};
      end
    end else if (bs_mode && s_rise) begin
      div_nxt = div_r + 2'h1;
      if ((cfg.oversample_speed == dfbi_pkg::SPD_FULL) ||
          (cfg.oversample_speed == dfbi_pkg::SPD_HALF && div_r[0]) ||
          (cfg.oversample_speed == dfbi_pkg::SPD_QUART && div_r == 2'h3)) begin
        lh_nxt   = {lh_r[6:0], dpin};
        rh_nxt   = {rh_r[6:0], wclk};
        push_nxt = 1'b1;
        pdat_nxt = '{bitstream: 1'b1, left: {23'h0, dpin}, right: {23'h0, wclk}};
      end
    end
    if (system_reset_bit_r) begin
      ovf_nxt = push && !in_ready; // set wins over clear
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lsh_r      <= '0;
      rsh_r      <= '0;
      lw_r       <= '0;
      div_r      <= '0;
      lh_r       <= '0;
      rh_r       <= '0;
      push       <= 1'b0;
      pdat_r     <= '0;
      overflow_r <= 1'b0;
    end else begin
      lsh_r      <= lsh_nxt;
      rsh_r      <= rsh_nxt;
      lw_r       <= lw_nxt;
      div_r      <= div_nxt;
      lh_r       <= lh_nxt;
      rh_r       <= rh_nxt;
      push       <= push_nxt;
      pdat_r     <= pdat_nxt;
      overflow_r <= ovf_nxt;
    end
  end

  dfbi_buf #(.W($bits(dfbi_pkg::dfbi_sample_t))) u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (in_ready),
    .in_data   (pdat_r),
    .out_valid (smp_valid),
    .out_ready (smp_ready),
    .out_data  (smp_data)
  );

  // ****************
  // zero flags
  // ****************
  logic zl_r, zr_r, zl_nxt, zr_nxt;
  function automatic logic bs_zero(input logic [7:0] h, input logic [1:0] dz);
    logic [3:0] ones;
    ones = 4'h0;
    for (int i = 0; i < 8; i++) begin
      ones = ones + {3'h0, h[i]};
    end
    if (dz[1]) begin
      bs_zero = (h == dfbi_pkg::PAT_96);
    end else begin
      bs_zero = dz[0] && (ones == dfbi_pkg::EVEN_ONES);
    end
  endfunction : bs_zero
  always_comb begin
    zl_nxt = zl_r;
    zr_nxt = zr_r;
    if (bs_mode) begin
      zl_nxt = bs_zero(lh_r, zen_r[dfbi_pkg::BIT_DZ_LO +: 2]);
      zr_nxt = bs_zero(rh_r, zen_r[dfbi_pkg::BIT_DZ_LO +: 2]);
    end else if (push) begin
      zl_nxt = zen_r[dfbi_pkg::BIT_WZ] && pdat_r.left == '0;
      zr_nxt = zen_r[dfbi_pkg::BIT_WZ] && pdat_r.right == '0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zl_r <= 1'b0;
      zr_r <= 1'b0;
    end else begin
      zl_r <= zl_nxt;
      zr_r <= zr_nxt;
    end
  end
  assign left_zero_pin_o     = zl_r;
  assign right_zero_pin_o    = zr_r;
  assign left_zero_pin_oe_n  = dual;
  assign right_zero_pin_oe_n = dual;
  assign zst                 = {6'h00, zr_r, zl_r};

  // ****************
  // checks
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence wr_sys_s;
    wr_go && sr_r[13:7] == dfbi_pkg::REG_SYS_MODE;
  endsequence
  sequence system_reset_bit_wr_s;
    wr_sys_s ##0 wdat[dfbi_pkg::BIT_RESET];
  endsequence
  mode_excl_a: assert property (!(filt_mode && bs_mode)) else $error("both modes");
  bs_enter_a: assert property (wr_sys_s ##0 (wdat[BIT_BS] && !system_reset_bit_r) |=> bs_mode) else $error("no bitstream");
  rst_pulse_a: assert property (system_reset_bit_wr_s |=> sys_reset_pulse ##1 !sys_reset_pulse) else $error("reset pulse");
  rst_clear_a: assert property (sys_reset_pulse |=> sys_r == dfbi_pkg::RST_SYS_MODE) else $error("reset value");
  bs_lock_a: assert property (wr_sys_s ##0 (bs_mode && !system_reset_bit_r) |=> $stable(sys_r[dfbi_pkg::BIT_BYPASS])) else $error("locked bit");
  dual_pin_a: assert property (dual |-> left_zero_pin_oe_n && right_zero_pin_oe_n) else $error("zero pin drive");
  zero_mirror_a: assert property (zst[1:0] == {right_zero_pin_o, left_zero_pin_o}) else $error("zero status");
  ratio_map_a: assert property (cfg.oversample_speed == dfbi_pkg::OS_16X |-> cfg.modulator_ratio == 5'd16) else $error("ratio");
  word_push_a: assert property (filt_mode && dual && w_rise |=> push ##0 pdat_r.left == ($past(lsh_r) & $past(wmask))) else $error("word");
  fmt16_a: assert property (push && !pdat_r.bitstream && cfg.word_format == dfbi_pkg::FMT_16 && $stable(fmt_r) |-> pdat_r.left[23:16] == 8'h00) else $error("width");
endmodule : dfbi_top
